// ### dv/tb_arith_logic_branch_exec.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// table of one-cycle operations, then flow, stack and register cases
// ----------------------------------------------------------------------
module tb_arith_logic_branch_exec;
    import albx_pkg::*;
    // op, operands, result, write (2: not checked), flags after
    typedef struct packed {
        albx_op_t o; logic [7:0] a, b, r; logic [1:0] w; logic [7:0] f;
    } albx_row_t;
    logic        mclk = 0, rst = 1, opValid = 0, regWr = 0, regRd = 0;
    logic        nextLong = 0;
    albx_op_t    opCode = OP_ADD;
    logic [7:0]  opA = 8'h00, opB = 8'h00, regAddr = 8'h00, regWdata = 8'h00;
    logic [11:0] offset = 12'h000;
    logic [15:0] zPtr = 16'h1234;      // fixed Z pointer target
    logic [2:0]  bitSel = 3'h3;        // fixed bit index for skips
    logic [21:0] popAddr = 22'h00ABCD; // fixed popped return address
    logic [7:0]  regRdata, resData, flags;
    logic        opReady, resWrite, pushStb, popStb;
    logic [21:0] pc, pushAddr;
    logic [15:0] stackPtr;
    logic [24:0] snap;
    int          miscompares = 0, nTests = 0, nCyc = 0, ePc = 0;
    albx_row_t   rows [24] = '{
        '{OP_ADD, 8'h0F, 8'h01, 8'h10, 2'h1, 8'h20},
        '{OP_ADD_CARRY, 8'h80, 8'h80, 8'h00, 2'h1, 8'h1B},
        '{OP_ADD_CARRY, 8'h01, 8'h01, 8'h03, 2'h1, 8'h00},
        '{OP_SUB, 8'h00, 8'h01, 8'hFF, 2'h1, 8'h35},
        '{OP_SUB_WITH_BORROW, 8'h05, 8'h02, 8'h02, 2'h1, 8'h00},
        '{OP_SUBTRACT_IMM, 8'h10, 8'h01, 8'h0F, 2'h1, 8'h20},
        '{OP_AND, 8'hF0, 8'h3C, 8'h30, 2'h1, 8'h20},
        '{OP_COMPARE, 8'h01, 8'h02, 8'h00, 2'h0, 8'h35},
        '{OP_EXCLUSIVE_OR, 8'hAA, 8'hAA, 8'h00, 2'h1, 8'h23},
        '{OP_ONES_INVERT, 8'h0F, 8'h00, 8'hF0, 2'h1, 8'h35},
        '{OP_TWOS_INVERT, 8'h00, 8'h00, 8'h00, 2'h1, 8'h02},
        '{OP_SET_BITS, 8'h01, 8'h80, 8'h81, 2'h1, 8'h14},
        '{OP_CLEAR_BITS, 8'hFF, 8'hFF, 8'h00, 2'h1, 8'h02},
        '{OP_PLUS_ONE, 8'h7F, 8'h00, 8'h80, 2'h1, 8'h0C},
        '{OP_MINUS_ONE, 8'h80, 8'h00, 8'h7F, 2'h1, 8'h18},
        '{OP_TEST_ZERO_MINUS, 8'h80, 8'h00, 8'h80, 2'h1, 8'h14},
        '{OP_ZERO_REGISTER, 8'h5A, 8'h00, 8'h00, 2'h1, 8'h02},
        '{OP_SET_ALL_ONES, 8'h00, 8'h00, 8'hFF, 2'h1, 8'h02},
        '{OP_COMPARE_IMM, 8'h10, 8'h20, 8'h00, 2'h0, 8'h15},
        '{OP_SUB_BORROW_IMM, 8'h00, 8'h00, 8'hFF, 2'h1, 8'h35},
        '{OP_COMPARE_CARRY, 8'h05, 8'h03, 8'h00, 2'h0, 8'h00},
        '{OP_AND_IMM, 8'h0F, 8'hF0, 8'h00, 2'h1, 8'h02},
        '{OP_OR, 8'h40, 8'h02, 8'h42, 2'h1, 8'h00},
        '{OP_LOGIC_OR_IMM, 8'h01, 8'h02, 8'h03, 2'h1, 8'h00}};

    albx_exec uut (.mclk, .rst, .opValid, .opCode, .opA, .opB, .offset,
        .zPtr, .bitSel, .nextLong, .popAddr, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .opReady, .resData, .resWrite, .pc, .pushAddr,
        .pushStb, .popStb, .stackPtr, .flags);

    // core clock, 10 ns period
    always #5 mclk = ~mclk;

    // compare and count
    task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
        nTests++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    // issue one operation, then count cycles until ready again
    task automatic op(albx_op_t o, logic [7:0] a, b, logic [11:0] k,
                      logic nl);
        @(posedge mclk);
        opValid <= 1'b1;
        opCode <= o;
        opA <= a;
        opB <= b;
        offset <= k;
        nextLong <= nl;
        @(posedge mclk);
        opValid <= 1'b0;
        #1 snap = {pushAddr, resWrite, pushStb, popStb};
        nCyc = 1;
        while (opReady !== 1'b1 && nCyc < 9) begin
            @(posedge mclk);
            #1 nCyc++;
        end
    endtask

    // register port: one-cycle strobes, read data in the next cycle
    task automatic regWrite(logic [7:0] ad, d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= ad;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic regRead(logic [7:0] ad, e, string nm);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= ad;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 chk(nm, regRdata, e);
    endtask

    // verdict and end of run
    task automatic complete_run();
        if (miscompares == 0 && nTests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end

    // main sequence
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        #1 chk("reset", {pc, flags, stackPtr, opReady}, 47'h1);
        foreach (rows[i]) begin
            op(rows[i].o, rows[i].a, rows[i].b, 12'h000, 1'b0);
            ePc++;
            chk("flags", flags, rows[i].f);
            if (rows[i].w != 2'h2) chk("wr", snap[2], rows[i].w[0]);
            if (rows[i].w == 2'h1) chk("res", resData, rows[i].r);
            chk("pcCyc", {pc, nCyc[2:0]}, {ePc[21:0], 3'h1});
        end
        op(OP_REL_JUMP, 8'h00, 8'h00, 12'hFFE, 1'b0);
        chk("rel_jump", {pc, nCyc[2:0]}, {ePc[21:0] - 22'h1, 3'h2});
        op(OP_JUMP_VIA_Z, 8'h00, 8'h00, 12'h000, 1'b0);
        chk("zjmp", {pc, nCyc[2:0]}, {22'h001234, 3'h2});
        regWrite(OFS_STACK_LOW, 8'h40);
        regWrite(OFS_STACK_HIGH, 8'h00);
        op(OP_REL_CALL, 8'h00, 8'h00, 12'h010, 1'b0);
        chk("call", {snap[1], snap[24:3], pc, nCyc[2:0], stackPtr},
            {1'b1, 22'h001235, 22'h001245, 3'h4, 16'h003E});
        op(OP_INTERRUPT_EXIT, 8'h00, 8'h00, 12'h000, 1'b0);
        chk("interrupt_exit", {snap[0], pc, nCyc[2:0], flags, stackPtr},
            {1'b1, 22'h00ABCD, 3'h5, 8'h80, 16'h0040});
        op(OP_CALL_VIA_Z, 8'h00, 8'h00, 12'h000, 1'b0);
        chk("call_via_z", {snap[24:3], pc, nCyc[2:0]},
            {22'h00ABCE, 22'h001234, 3'h4});
        op(OP_SUBROUTINE_EXIT, 8'h00, 8'h00, 12'h000, 1'b0);
        chk("ret", {snap[0], pc, nCyc[2:0]}, {1'b1, 22'h00ABCD, 3'h5});
        op(OP_SKIP_IF_EQUAL, 8'h55, 8'h55, 12'h000, 1'b1);
        chk("skipEq", {pc, nCyc[2:0]}, {22'h00ABD0, 3'h3});
        op(OP_SKIP_IF_EQUAL, 8'h55, 8'h54, 12'h000, 1'b1);
        chk("skipNe", {pc, nCyc[2:0]}, {22'h00ABD1, 3'h1});
        op(OP_SKIP_BIT_SET, 8'h08, 8'h00, 12'h000, 1'b0);
        chk("bitSet", {pc, nCyc[2:0]}, {22'h00ABD3, 3'h2});
        op(OP_SKIP_BIT_CLEAR, 8'h08, 8'h00, 12'h000, 1'b0);
        chk("bitClr", {pc, nCyc[2:0], flags}, {22'h00ABD4, 3'h1, 8'h80});
        regRead(OFS_STATUS, 8'h80, "status");
        regWrite(OFS_STATUS, 8'h00);
        regRead(OFS_STATUS, 8'h00, "statusWr");
        regRead(8'h40, 8'h00, "unmapped");
        complete_run();
    end
endmodule // tb_arith_logic_branch_exec

// ### src/albx_alu.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// combinational byte arithmetic and flag generation
// ----------------------------------------------------------------------
module albx_alu
    import albx_pkg::*;
(
    input  wire albx_op_t   op,       // operation
    input  wire logic [7:0] opA,      // destination operand
    input  wire logic [7:0] opB,      // source or immediate
    input  wire logic [7:0] flagsIn,  // present status flags
    output logic      [7:0] result,   // computed byte
    output logic      [7:0] flagsOut, // updated status flags
    output logic            writeBack // result goes to destination
);
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic       isSub;
    logic       isLogic;
    logic       keepC;
    logic       keepH;
    logic       noFlags;
    logic [8:0] sum;
    logic [7:0] r;
    logic       cOut;
    logic       hOut;
    logic       vOut;

    // operand steering per operation
    always_comb begin
        a       = opA;
        b       = opB;
        cin     = 1'b0;
        isSub   = 1'b0;
        isLogic = 1'b0;
        keepC   = 1'b0;
        keepH   = 1'b0;
        noFlags = 1'b0;
        writeBack = 1'b1;
        case (op)
            OP_ADD: ;                                         // RL1
            OP_ADD_CARRY: cin = flagsIn[FLG_C];               // RL2
            OP_SUB, OP_SUBTRACT_IMM: isSub = 1'b1;            // RL3
            OP_SUB_WITH_BORROW, OP_SUB_BORROW_IMM: begin      // RL4
                isSub = 1'b1;
                cin   = flagsIn[FLG_C];
            end
            OP_COMPARE, OP_COMPARE_IMM: begin                 // RL14
                isSub = 1'b1;
                writeBack = 1'b0;
            end
            OP_COMPARE_CARRY: begin                           // RL14
                isSub = 1'b1;
                cin   = flagsIn[FLG_C];
                writeBack = 1'b0;
            end
            OP_ONES_INVERT: begin                             // RL6
                a = ALL_ONES;
                b = opA;
                isSub = 1'b1;
                keepH = 1'b1;
            end
            OP_TWOS_INVERT: begin                             // RL6
                a = ALL_ZERO;
                b = opA;
                isSub = 1'b1;
            end
            OP_PLUS_ONE: begin                                // RL8
                b = ONE_BYTE;
                keepC = 1'b1;
                keepH = 1'b1;
            end
            OP_MINUS_ONE: begin                               // RL8
                b = ONE_BYTE;
                isSub = 1'b1;
                keepC = 1'b1;
                keepH = 1'b1;
            end
            OP_AND, OP_AND_IMM, OP_OR, OP_LOGIC_OR_IMM, OP_EXCLUSIVE_OR,
            OP_SET_BITS, OP_CLEAR_BITS, OP_TEST_ZERO_MINUS,
            OP_ZERO_REGISTER: begin                           // RL5
                isLogic = 1'b1;
                keepC = 1'b1;
                keepH = 1'b1;
            end
            OP_SET_ALL_ONES: noFlags = 1'b1;                  // RL10
            default: begin
                noFlags = 1'b1;
                writeBack = 1'b0;
            end
        endcase
    end

    // adder shared by add and subtract forms
    assign sum  = isSub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin})
                        : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
    assign cOut = sum[8];
    assign hOut = isSub ? ((~a[3] & b[3]) | (b[3] & sum[3]) | (sum[3] & ~a[3]))
                        : ((a[3] & b[3]) | (b[3] & ~sum[3]) | (~sum[3] & a[3]));
    assign vOut = isSub ? ((a[7] & ~b[7] & ~sum[7]) | (~a[7] & b[7] & sum[7]))
                        : ((a[7] & b[7] & ~sum[7]) | (~a[7] & ~b[7] & sum[7]));

    // logic results
    always_comb begin
        r = sum[7:0];
        case (op)
            OP_AND, OP_AND_IMM: r = opA & opB;                // RL5
            OP_OR, OP_LOGIC_OR_IMM, OP_SET_BITS: r = opA | opB; // RL7
            OP_EXCLUSIVE_OR: r = opA ^ opB;                   // RL5
            OP_CLEAR_BITS: r = opA & (ALL_ONES - opB);        // RL7
            OP_TEST_ZERO_MINUS: r = opA & opA;                // RL9
            OP_ZERO_REGISTER: r = opA ^ opA;                  // RL10
            OP_SET_ALL_ONES: r = ALL_ONES;                    // RL10
            default: r = sum[7:0];
        endcase
    end

    // flag merge: Z and N from result, S = N ^ V
    always_comb begin
        flagsOut = flagsIn;
        if (!noFlags) begin
            flagsOut[FLG_Z] = (r == ALL_ZERO);                // RL17
            flagsOut[FLG_N] = r[7];                           // RL17
            flagsOut[FLG_V] = isLogic ? 1'b0 : vOut;
            flagsOut[FLG_S] = r[7] ^ (isLogic ? 1'b0 : vOut); // RL17
            if (!keepC)
                flagsOut[FLG_C] = (op == OP_ONES_INVERT) ? 1'b1 : cOut;
            if (!keepH)
                flagsOut[FLG_H] = hOut;
        end
        result = r;
    end
endmodule // albx_alu

// ### src/albx_exec.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ps
// Contract
// RL1 - add stores Rd+Rr, updates Z C N V S H, one cycle
// RL2 - add with carry stores Rd+Rr+C, updates six flags, one cycle
// RL3 - subtract register or immediate, updates six flags, one cycle
// RL4 - subtract with borrow also subtracts carry, six flags, one cycle
// RL5 - and, or, xor update only Z N V S, keep C and H
// RL6 - ones invert is FF-Rd with Z C N V S; twos invert adds H
// RL7 - set bits ORs mask; clear bits ANDs FF-mask; Z N V S
// RL8 - increment and decrement by one, Z N V S only, carry kept
// RL9 - test ANDs register with itself, value kept, Z N V S
// RL10 - zero register xors itself with flags; set all ones keeps flags
// RL11 - relative jump pc+k+1; Z jump loads low 16 bits; two cycles
// RL12 - calls push return address, jump likewise, three or four cycles
// RL13 - skip if equal advances pc two or three on match, else one
// RL14 - compares subtract without write back, update six flags
// RL15 - bit skips skip on cleared or set bit, one to three cycles
// RL16 - returns pop pc in four or five; interrupt return sets I
// RL17 - Z on zero result, N is msb, S is N xor V
module albx_exec
    import albx_pkg::*;
#(
    parameter int PC_WIDTH = 22 // program counter width for call/return timing; pc is always 22 bits
) (
    input  wire logic        mclk,     // core clock
    input  wire logic        rst,      // asynchronous reset
    input  wire logic        opValid,  // operation issued this cycle
    input  wire albx_pkg::albx_op_t opCode, // operation
    input  wire logic [7:0]  opA,      // destination register value
    input  wire logic [7:0]  opB,      // source register or immediate
    input  wire logic [11:0] offset,   // relative jump offset
    input  wire logic [15:0] zPtr,     // Z pointer
    input  wire logic [2:0]  bitSel,   // bit select for bit skips
    input  wire logic        nextLong, // next instruction is two words
    input  wire logic [21:0] popAddr,  // return address read from stack
    input  wire logic [7:0]  regAddr,  // register port address
    input  wire logic [7:0]  regWdata, // register port write data
    input  wire logic        regWr,    // register write strobe
    input  wire logic        regRd,    // register read strobe
    output logic      [7:0]  regRdata, // read data, cycle after strobe
    output logic             opReady,  // ready to take an operation
    output logic      [7:0]  resData,  // result byte
    output logic             resWrite, // destination write pulse
    output logic      [21:0] pc,       // program counter
    output logic      [21:0] pushAddr, // return address to push
    output logic             pushStb,  // push request pulse
    output logic             popStb,   // pop request pulse
    output logic      [15:0] stackPtr, // stack pointer
    output logic      [7:0]  flags     // status flags
);
    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (PC_WIDTH != 16 && PC_WIDTH != 22) begin : g_bad_width
        $error("PC_WIDTH must be 16 or 22");
    end

    localparam logic WIDE_PC = (PC_WIDTH == 22);

    // ------------------------------------------------------------------
    // datapath instances
    // ------------------------------------------------------------------
    logic [7:0]  aluResult;
    logic [7:0]  aluFlags;
    logic        aluWrite;
    logic [21:0] flowPc;
    logic [2:0]  flowCycles;
    logic [2:0]  busyLeft;
    logic [7:0]  opCount;
    logic        take;
    logic        isCall;
    logic        isRet;
    logic [21:0] next_pc;
    logic [7:0]  next_flags;
    logic [15:0] next_stackPtr;

    albx_alu u_alu (
        .op        (opCode),
        .opA       (opA),
        .opB       (opB),
        .flagsIn   (flags),
        .result    (aluResult),
        .flagsOut  (aluFlags),
        .writeBack (aluWrite)
    );

    albx_flow u_flow (
        .op       (opCode),
        .pc       (pc),
        .offset   (offset),
        .zPtr     (zPtr),
        .popAddr  (popAddr),
        .opA      (opA),
        .opB      (opB),
        .bitSel   (bitSel),
        .nextLong (nextLong),
        .widePc   (WIDE_PC),
        .nextPc   (flowPc),
        .cycles   (flowCycles)
    );

    // ------------------------------------------------------------------
    // issue decode
    // ------------------------------------------------------------------
    assign take   = opValid && opReady;
    assign isCall = (opCode == OP_REL_CALL) || (opCode == OP_CALL_VIA_Z);
    assign isRet  = (opCode == OP_SUBROUTINE_EXIT)
                 || (opCode == OP_INTERRUPT_EXIT);

    // register port writes take effect, then operation flags override
    always_comb begin
        next_flags    = flags;
        next_stackPtr = stackPtr;
        if (regWr && regAddr == OFS_STATUS)
            next_flags = regWdata;
        if (regWr && regAddr == OFS_STACK_LOW)
            next_stackPtr[7:0] = regWdata;
        if (regWr && regAddr == OFS_STACK_HIGH)
            next_stackPtr[15:8] = regWdata;
        if (take) begin
            next_flags = aluFlags;                       // RL17
            if (opCode == OP_INTERRUPT_EXIT)
                next_flags[FLG_I] = 1'b1;                // RL16
            if (isCall)
                next_stackPtr = stackPtr - SP_STEP;      // RL12
            if (isRet)
                next_stackPtr = stackPtr + SP_STEP;      // RL16
        end
    end

    assign next_pc = take ? flowPc : pc;

    // ------------------------------------------------------------------
    // architectural state
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pc       <= PC_RESET;
            flags    <= STATUS_RESET;
            stackPtr <= STACK_RESET;
        end else begin
            pc       <= next_pc;
            flags    <= next_flags;
            stackPtr <= next_stackPtr;
        end
    end

    // result and stack strobes, one cycle after issue
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resData  <= ALL_ZERO;
            resWrite <= 1'b0;
            pushAddr <= PC_RESET;
            pushStb  <= 1'b0;
            popStb   <= 1'b0;
        end else begin
            resData  <= aluResult;
            resWrite <= take && aluWrite;                // RL14
            pushAddr <= pc + PC_ONE;                     // RL12
            pushStb  <= take && isCall;                  // RL12
            popStb   <= take && isRet;                   // RL16
        end
    end

    // ------------------------------------------------------------------
    // multi-cycle hold: ready drops for the extra cycles
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busyLeft <= 3'h0;
            opReady  <= 1'b1;
            opCount  <= ALL_ZERO;
        end else if (take) begin
            busyLeft <= flowCycles - CYC_ONE;            // RL11
            opReady  <= (flowCycles == CYC_ONE);         // RL1
            opCount  <= opCount + ONE_BYTE;
        end else if (busyLeft != 3'h0) begin
            busyLeft <= busyLeft - CYC_ONE;
            opReady  <= (busyLeft == CYC_ONE);
        end
    end

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    logic [7:0] rdMux;
    assign rdMux = (regAddr == OFS_STATUS)     ? flags :
                   (regAddr == OFS_STACK_LOW)  ? stackPtr[7:0] :
                   (regAddr == OFS_STACK_HIGH) ? stackPtr[15:8] :
                   (regAddr == OFS_PC_LOW)     ? pc[7:0] :
                   (regAddr == OFS_PC_MID)     ? pc[15:8] :
                   (regAddr == OFS_PC_HIGH)    ? {2'b00, pc[21:16]} :
                   (regAddr == OFS_BUSY)       ? {4'h0, ~opReady, busyLeft} :
                   (regAddr == OFS_OP_COUNT)   ? opCount : ALL_ZERO;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            regRdata <= ALL_ZERO;
        else
            regRdata <= regRd ? rdMux : ALL_ZERO;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_jump_issue;
        take && (opCode == OP_REL_JUMP || opCode == OP_JUMP_VIA_Z);
    endsequence

    a_jump_two_cycles: assert property (@(posedge mclk) disable iff (rst)
        s_jump_issue |=> !opReady ##1 opReady) // RL11
        else $error("jump did not take two cycles");

    a_z_jump_high: assert property (@(posedge mclk) disable iff (rst)
        take && opCode == OP_JUMP_VIA_Z |=> pc[21:16] == 6'h00) // RL11
        else $error("indirect jump left upper pc bits");

    a_single_cycle: assert property (@(posedge mclk) disable iff (rst)
        take && opCode == OP_ADD |=> opReady) // RL1
        else $error("add took more than one cycle");

    a_logic_keeps_c: assert property (@(posedge mclk) disable iff (rst)
        take && (opCode == OP_AND || opCode == OP_EXCLUSIVE_OR)
        |=> flags[FLG_C] == $past(flags[FLG_C])
            && flags[FLG_H] == $past(flags[FLG_H])) // RL5
        else $error("logic op changed carry or half carry");

    a_sign_flag: assert property (@(posedge mclk) disable iff (rst)
        take && opCode == OP_SUB
        |=> flags[FLG_S] == (flags[FLG_N] ^ flags[FLG_V])) // RL17
        else $error("sign flag is not N xor V");

    a_compare_nowrite: assert property (@(posedge mclk) disable iff (rst)
        take && opCode == OP_COMPARE |=> !resWrite) // RL14
        else $error("compare wrote a result");

    a_call_push: assert property (@(posedge mclk) disable iff (rst)
        take && isCall |=> pushStb ##1 !opReady) // RL12
        else $error("call did not push");

    a_interrupt_exit_sets_i: assert property (@(posedge mclk) disable iff (rst)
        take && opCode == OP_INTERRUPT_EXIT |=> flags[FLG_I]) // RL16
        else $error("interrupt return left I clear");

    a_set_ones_flags: assert property (@(posedge mclk) disable iff (rst)
        take && opCode == OP_SET_ALL_ONES && !regWr
        |=> flags == $past(flags) && resData == ALL_ONES) // RL10
        else $error("set all ones changed flags");
endmodule // albx_exec

// ### src/albx_flow.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// program flow target and cycle count decision
// ----------------------------------------------------------------------
module albx_flow
    import albx_pkg::*;
(
    input  wire albx_op_t    op,        // operation
    input  wire logic [21:0] pc,        // present program counter
    input  wire logic [11:0] offset,    // signed relative offset
    input  wire logic [15:0] zPtr,      // Z pointer
    input  wire logic [21:0] popAddr,   // return address from stack
    input  wire logic [7:0]  opA,       // first register
    input  wire logic [7:0]  opB,       // second register
    input  wire logic [2:0]  bitSel,    // bit select for skips
    input  wire logic        nextLong,  // following word is two words
    input  wire logic        widePc,    // 22-bit pc: longer call/return
    output logic      [21:0] nextPc,    // program counter after op
    output logic      [2:0]  cycles     // cycles the op takes
);
    logic [21:0] relTarget;
    logic [21:0] zTarget;
    logic        skip;
    logic [21:0] skipStep;
    logic [2:0]  skipCyc;

    assign relTarget = pc + {{10{offset[11]}}, offset} + PC_ONE;   // RL11
    assign zTarget   = {6'h00, zPtr};                              // RL11
    assign skipStep  = nextLong ? PC_THREE : PC_TWO;              // RL13
    assign skipCyc   = nextLong ? CYC_CALL : CYC_JUMP;            // RL15

    // skip conditions
    always_comb begin
        case (op)
            OP_SKIP_IF_EQUAL:  skip = (opA == opB);                // RL13
            OP_SKIP_BIT_CLEAR: skip = ~opA[bitSel];                // RL15
            OP_SKIP_BIT_SET:   skip = opA[bitSel];                 // RL15
            default:           skip = 1'b0;
        endcase
    end

    // target and duration
    always_comb begin
        nextPc = pc + PC_ONE;
        cycles = CYC_ONE;
        case (op)
            OP_REL_JUMP: begin                                     // RL11
                nextPc = relTarget;
                cycles = CYC_JUMP;
            end
            OP_JUMP_VIA_Z: begin                                   // RL11
                nextPc = zTarget;
                cycles = CYC_JUMP;
            end
            OP_REL_CALL: begin                                     // RL12
                nextPc = relTarget;
                cycles = widePc ? CYC_CALL4 : CYC_CALL;
            end
            OP_CALL_VIA_Z: begin                                   // RL12
                nextPc = zTarget;
                cycles = widePc ? CYC_CALL4 : CYC_CALL;
            end
            OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin           // RL16
                nextPc = popAddr;
                cycles = widePc ? CYC_RET5 : CYC_RET;
            end
            OP_SKIP_IF_EQUAL, OP_SKIP_BIT_CLEAR, OP_SKIP_BIT_SET: begin
                if (skip) begin
                    nextPc = pc + skipStep;
                    cycles = skipCyc;
                end
            end
            default: ;
        endcase
    end
endmodule // albx_flow

// ### src/albx_pkg.sv
package albx_pkg;
    // ------------------------------------------------------------------
    // register offsets on the plain register port
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_STACK_LOW  = 8'h3D;
    localparam logic [7:0] OFS_STACK_HIGH = 8'h3E;
    localparam logic [7:0] OFS_STATUS     = 8'h5F;
    localparam logic [7:0] OFS_PC_LOW     = 8'h60; // program counter view
    localparam logic [7:0] OFS_PC_MID     = 8'h61;
    localparam logic [7:0] OFS_PC_HIGH    = 8'h62;
    localparam logic [7:0] OFS_BUSY       = 8'h63; // busy and cycle count
    localparam logic [7:0] OFS_OP_COUNT   = 8'h64; // issued operations

    // ------------------------------------------------------------------
    // status flag bit positions
    // ------------------------------------------------------------------
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;
    localparam int FLG_I = 7;

    // ------------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------------
    localparam logic [7:0]  STATUS_RESET = 8'h00;
    localparam logic [15:0] STACK_RESET  = 16'h0000;
    localparam logic [21:0] PC_RESET     = 22'h000000;
    localparam logic [7:0]  ALL_ONES     = 8'hFF;
    localparam logic [7:0]  ALL_ZERO     = 8'h00;
    localparam logic [7:0]  ONE_BYTE     = 8'h01;
    localparam logic [21:0] PC_ONE       = 22'h000001;
    localparam logic [21:0] PC_TWO       = 22'h000002;
    localparam logic [21:0] PC_THREE     = 22'h000003;
    localparam logic [15:0] SP_STEP      = 16'h0002; // two-byte return word

    // ------------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------------
    localparam logic [2:0] CYC_ONE   = 3'h1;
    localparam logic [2:0] CYC_JUMP  = 3'h2;
    localparam logic [2:0] CYC_CALL  = 3'h3;
    localparam logic [2:0] CYC_CALL4 = 3'h4;
    localparam logic [2:0] CYC_RET   = 3'h4;
    localparam logic [2:0] CYC_RET5  = 3'h5;

    // ------------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_IMM, OP_SUB_WITH_BORROW,
        OP_SUB_BORROW_IMM, OP_AND, OP_AND_IMM, OP_OR, OP_LOGIC_OR_IMM,
        OP_EXCLUSIVE_OR, OP_ONES_INVERT, OP_TWOS_INVERT, OP_SET_BITS,
        OP_CLEAR_BITS, OP_PLUS_ONE, OP_MINUS_ONE, OP_TEST_ZERO_MINUS,
        OP_ZERO_REGISTER, OP_SET_ALL_ONES, OP_REL_JUMP, OP_JUMP_VIA_Z,
        OP_REL_CALL, OP_CALL_VIA_Z, OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT,
        OP_SKIP_IF_EQUAL, OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMM,
        OP_SKIP_BIT_CLEAR, OP_SKIP_BIT_SET
    } albx_op_t;
endpackage
